// ### sfrm_consts.vh
// constants for the special function register bank
`ifndef SFRM_CONSTS_VH
`define SFRM_CONSTS_VH
`define SFRM_IDX_PTR_LO 9'h082
`define SFRM_IDX_PTR_HI 9'h083
`define SFRM_IDX_CLKDIV 9'h095
`define SFRM_IDX_AUX 9'h0a2
`define SFRM_IDX_CMP_ONE 9'h0ac
`define SFRM_IDX_CMP_TWO 9'h0ad
`define SFRM_IDX_BAUD_CTL 9'h0bd
`define SFRM_IDX_BAUD_LO 9'h0be
`define SFRM_IDX_BAUD_HI 9'h0bf
`define SFRM_IDX_TWI_CTL 9'h0d8
`define SFRM_IDX_TWI_DATA 9'h0da
`define SFRM_IDX_TWI_ADDR 9'h0db
`define SFRM_IDX_ACC 9'h0e0
`define SFRM_IDX_FLASH_CTL 9'h0e4
`define SFRM_IDX_FLASH_DATA 9'h0e5
`define SFRM_IDX_FLASH_ADR_LO 9'h0e6
`define SFRM_IDX_FLASH_ADR_HI 9'h0e7
`define SFRM_IDX_BREG 9'h0f0
`define SFRM_IDX_BITOP 9'h100
`define SFRM_IDX_IRQ_STAT 9'h101
`define SFRM_IDX_IRQ_MASK 9'h102
`define SFRM_BITGRP_TWI 5'h1b
`define SFRM_BITGRP_ACC 5'h1c
`define SFRM_BITGRP_BREG 5'h1e
`define SFRM_RST_BYTE 8'h00
`define SFRM_RST_AUX 5'h00
`define SFRM_RST_BAUD_CTL 2'h0
`define SFRM_RST_CMP 4'h0
`define SFRM_RST_TWI_CTL 8'h00
`define SFRM_RST_IRQ 4'h0
`define SFRM_FLASH_RSVD 3'h7
`define SFRM_AUX_LOWPWR 7
`define SFRM_AUX_BRK 6
`define SFRM_AUX_T1TOG 5
`define SFRM_AUX_T0TOG 4
`define SFRM_AUX_SWRST 3
`define SFRM_AUX_PSEL 0
`define SFRM_CMP_EN 5
`define SFRM_CMP_FLAG 0
`define SFRM_TWI_EN 6
`define SFRM_TWI_START 5
`define SFRM_TWI_STOP 4
`define SFRM_TWI_FLAG 3
`define SFRM_TWI_ACK 2
`define SFRM_TWI_CSEL 0
`define SFRM_BITOP_VAL 8
`define SFRM_IRQ_CMP_ONE 0
`define SFRM_IRQ_CMP_TWO 1
`define SFRM_IRQ_FLASH 2
`define SFRM_IRQ_TWI 3
`define SFRM_HTRANS_NONSEQ 2'b10
`endif

// ### sfrm_regs.v
// special function register bank behind an ahb-lite slave
//
// Summary of operation
// - reserved bits are written zero; device may read back anything.
// - fixed-zero bits always read back as zero.
// - fixed-one bits always read back as one.
// - accumulator, b register and two-wire control allow single-bit access.
// - auxiliary register at a2: low power, break reset, toggles, reset, select.
// - baud control at bd: source select bit 1, enable bit 0.
// - baud divisor low byte at be, high byte at bf, reset zero.
// - comparator controls at ac/ad: enable, selects, pin, output, change flag.
// - cpu clock divider register at 95, reset zero.
// - data pointer high at 83, low at 82, reset zero.
// - flash address high e7, low e6, data e5, reset zero.
// - reading e4 gives busy and four flash status bits, reset 70.
// - writing e4 loads a write-only flash command code.
// - two-wire own address at db: address bits 7..1, general call bit 0.
// - two-wire control at d8: enable, start, stop, flag, ack, clock select.
`include "sfrm_consts.vh"
module sfrm_regs (
    input wire ref_clk,
    input wire rst_b,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata_r,
    output reg hreadyout_r,
    output reg hresp_r,
    input wire [1:0] cmp_out_pin,
    input wire flash_busy,
    input wire [3:0] flash_status,
    input wire twi_flag_set,
    output reg [7:0] accumulator_r,
    output reg [7:0] multiply_divide_operand_r,
    output reg [7:0] data_pointer_low_r,
    output reg [7:0] data_pointer_high_r,
    output reg [7:0] cpu_clock_divider_r,
    output reg clock_low_power_r,
    output reg break_reset_enable_r,
    output reg timer_one_toggle_enable_r,
    output reg timer_zero_toggle_enable_r,
    output reg software_reset_trigger_r,
    output reg pointer_select_r,
    output reg baud_source_select_r,
    output reg baud_generator_enable_r,
    output reg [7:0] baud_divisor_low_r,
    output reg [7:0] baud_divisor_high_r,
    output wire [7:0] comparator_cfg,
    output reg [7:0] flash_address_low_r,
    output reg [7:0] flash_address_high_r,
    output reg [7:0] flash_data_r,
    output reg [7:0] flash_command_code_r,
    output reg flash_command_strobe_r,
    output reg [7:0] twowire_own_address_r,
    output reg [7:0] twowire_control_r,
    output reg irq_r
);

// reserved bits have no storage, so they cost no flops; they read zero, except the flash ones, which read one
reg pend_r;
reg pend_wr_r;
reg [8:0] pend_idx_r;
reg [7:0] twowire_data_r;
reg [7:0] bitop_addr_r;
reg [3:0] irq_stat_r;
reg [3:0] irq_mask_r;
reg flash_busy_prev_r;
reg [31:0] rd_nxt;
reg [8:0] wr_idx;
reg [7:0] wr_dat;
reg [7:0] bit_src;
reg wr_byte;
reg bit_val;
wire [15:0] cmp_rd;
wire [1:0] cmp_event;
wire [3:0] irq_event;
wire [3:0] irq_stat_nxt;
wire addr_ok;
wire take;
wire wr_en;
wire flash_done;

// the index sits in haddr[10:2]; any other address bit set is unmapped
// hsize is not decoded: every register is one aligned word
assign addr_ok = (haddr[31:11] == 21'h000000) && (haddr[1:0] == 2'b00);
assign take = hsel && hready
    && (htrans == `SFRM_HTRANS_NONSEQ);
assign wr_en = pend_r && pend_wr_r;

// one wait state: the write and the read both act in the second cycle,
// so a read right after a write always sees the new value
// hresp_r stays a flop so every bus output leaves a register
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        pend_r <= 1'b0;
        pend_wr_r <= 1'b0;
        pend_idx_r <= 9'h000;
        hreadyout_r <= 1'b1;
        hresp_r <= 1'b0;
        hrdata_r <= 32'h00000000;
    end else begin
        hresp_r <= 1'b0;
        if (pend_r) begin
            pend_r <= 1'b0;
            hreadyout_r <= 1'b1;
            if (!pend_wr_r) begin
                hrdata_r <= rd_nxt;
            end
        end else if (take) begin
            pend_r <= 1'b1;
            pend_wr_r <= hwrite;
            pend_idx_r <= addr_ok ? haddr[10:2] : 9'h1ff;
            hreadyout_r <= 1'b0;
        end
    end
end

// current value of a bit-addressable register, for read-modify-write
// a stray bit address outside the three groups writes nothing
always @* begin
    case (hwdata[7:3])
        `SFRM_BITGRP_ACC: bit_src = accumulator_r;
        `SFRM_BITGRP_BREG: bit_src = multiply_divide_operand_r;
        `SFRM_BITGRP_TWI: bit_src = twowire_control_r;
        default: bit_src = 8'h00;
    endcase
end

// a bit operation turns into a byte write of the owning register
always @* begin
    wr_idx = pend_idx_r;
    wr_dat = hwdata[7:0];
    wr_byte = wr_en;
    if (pend_idx_r == `SFRM_IDX_BITOP) begin
        wr_idx = {1'b0, hwdata[7:3], 3'b000};
        wr_dat = bit_src;
        wr_dat[hwdata[2:0]] = hwdata[`SFRM_BITOP_VAL];
        wr_byte = wr_en && ((hwdata[7:3] == `SFRM_BITGRP_ACC)
            || (hwdata[7:3] == `SFRM_BITGRP_BREG)
            || (hwdata[7:3] == `SFRM_BITGRP_TWI));
    end
end

// read side of a bit operation, from the last stored bit address
always @* begin
    case (bitop_addr_r[7:3])
        `SFRM_BITGRP_ACC: bit_val = accumulator_r[bitop_addr_r[2:0]];
        `SFRM_BITGRP_BREG: bit_val = multiply_divide_operand_r[bitop_addr_r[2:0]];
        `SFRM_BITGRP_TWI: bit_val = twowire_control_r[bitop_addr_r[2:0]];
        default: bit_val = 1'b0;
    endcase
end

// plain byte registers
// the stored bit address shares their write strobe
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        accumulator_r <= `SFRM_RST_BYTE;
        multiply_divide_operand_r <= `SFRM_RST_BYTE;
        data_pointer_low_r <= `SFRM_RST_BYTE;
        data_pointer_high_r <= `SFRM_RST_BYTE;
        cpu_clock_divider_r <= `SFRM_RST_BYTE;
        baud_divisor_low_r <= `SFRM_RST_BYTE;
        baud_divisor_high_r <= `SFRM_RST_BYTE;
        flash_address_low_r <= `SFRM_RST_BYTE;
        flash_address_high_r <= `SFRM_RST_BYTE;
        flash_data_r <= `SFRM_RST_BYTE;
        twowire_own_address_r <= `SFRM_RST_BYTE;
        bitop_addr_r <= `SFRM_RST_BYTE;
    end else if (wr_byte) begin
        case (wr_idx)
            `SFRM_IDX_ACC: accumulator_r <= wr_dat;
            `SFRM_IDX_BREG: multiply_divide_operand_r <= wr_dat;
            `SFRM_IDX_PTR_LO: data_pointer_low_r <= wr_dat;
            `SFRM_IDX_PTR_HI: data_pointer_high_r <= wr_dat;
            `SFRM_IDX_CLKDIV: cpu_clock_divider_r <= wr_dat;
            `SFRM_IDX_BAUD_LO: baud_divisor_low_r <= wr_dat;
            `SFRM_IDX_BAUD_HI: baud_divisor_high_r <= wr_dat;
            `SFRM_IDX_FLASH_ADR_LO: flash_address_low_r <= wr_dat;
            `SFRM_IDX_FLASH_ADR_HI: flash_address_high_r <= wr_dat;
            `SFRM_IDX_FLASH_DATA: flash_data_r <= wr_dat;
            `SFRM_IDX_TWI_ADDR: twowire_own_address_r <= wr_dat;
            default: begin
            end
        endcase
        if (pend_idx_r == `SFRM_IDX_BITOP) begin
            bitop_addr_r <= hwdata[7:0];
        end
    end
end

// no reset: contents are meaningless until software loads them
always @(posedge ref_clk) begin
    if (wr_byte && (wr_idx == `SFRM_IDX_TWI_DATA)) begin
        twowire_data_r <= wr_dat;
    end
end

// auxiliary functions; the reset trigger is a one-cycle pulse
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        {clock_low_power_r, break_reset_enable_r, timer_one_toggle_enable_r,
            timer_zero_toggle_enable_r, pointer_select_r} <= `SFRM_RST_AUX;
        software_reset_trigger_r <= 1'b0;
    end else begin
        software_reset_trigger_r <= 1'b0;
        if (wr_byte && (wr_idx == `SFRM_IDX_AUX)) begin
            clock_low_power_r <= wr_dat[`SFRM_AUX_LOWPWR];
            break_reset_enable_r <= wr_dat[`SFRM_AUX_BRK];
            timer_one_toggle_enable_r <= wr_dat[`SFRM_AUX_T1TOG];
            timer_zero_toggle_enable_r <= wr_dat[`SFRM_AUX_T0TOG];
            software_reset_trigger_r <= wr_dat[`SFRM_AUX_SWRST];
            pointer_select_r <= wr_dat[`SFRM_AUX_PSEL];
        end
    end
end

// baud generator control
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        {baud_source_select_r, baud_generator_enable_r} <= `SFRM_RST_BAUD_CTL;
    end else if (wr_byte && (wr_idx == `SFRM_IDX_BAUD_CTL)) begin
        {baud_source_select_r, baud_generator_enable_r} <= wr_dat[1:0];
    end
end

// flash command is write-only and never disturbs the status view
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        flash_command_code_r <= `SFRM_RST_BYTE;
        flash_command_strobe_r <= 1'b0;
        flash_busy_prev_r <= 1'b0;
    end else begin
        flash_busy_prev_r <= flash_busy;
        flash_command_strobe_r <= 1'b0;
        if (wr_byte && (wr_idx == `SFRM_IDX_FLASH_CTL)) begin
            flash_command_code_r <= wr_dat;
            flash_command_strobe_r <= 1'b1;
        end
    end
end

// flash_busy is on this clock, so one stage is enough to find its fall
assign flash_done = flash_busy_prev_r && !flash_busy;

// two-wire control; the flag is set by the bus engine and cleared
// only by writing zero, and a set in the same cycle wins
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        twowire_control_r <= `SFRM_RST_TWI_CTL;
    end else begin
        if (wr_byte && (wr_idx == `SFRM_IDX_TWI_CTL)) begin
            twowire_control_r[`SFRM_TWI_EN] <= wr_dat[`SFRM_TWI_EN];
            twowire_control_r[`SFRM_TWI_START] <= wr_dat[`SFRM_TWI_START];
            twowire_control_r[`SFRM_TWI_STOP] <= wr_dat[`SFRM_TWI_STOP];
            twowire_control_r[`SFRM_TWI_ACK] <= wr_dat[`SFRM_TWI_ACK];
            twowire_control_r[`SFRM_TWI_CSEL] <= wr_dat[`SFRM_TWI_CSEL];
            if (!wr_dat[`SFRM_TWI_FLAG]) begin
                twowire_control_r[`SFRM_TWI_FLAG] <= 1'b0;
            end
        end
        if (twi_flag_set) begin
            twowire_control_r[`SFRM_TWI_FLAG] <= 1'b1;
        end
    end
end

// comparators: the analog output is a pin, so it is synchronised and
// only taken once the last two stages agree
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
        localparam [8:0] MY_IDX = (gi == 0) ? `SFRM_IDX_CMP_ONE
            : `SFRM_IDX_CMP_TWO;
        reg [2:0] sync_r;
        reg filt_r;
        reg [3:0] ctl_r;
        reg flag_r;
        wire stable;
        wire change;
        wire wr_ctl;
        assign stable = (sync_r[2] == sync_r[1]);
        // sync_r[0] may be metastable and is read only by the shift
        // ctl_r[3] is the enable bit: a disabled comparator raises no flag
        assign change = stable && (sync_r[2] != filt_r) && ctl_r[3];
        assign wr_ctl = wr_byte && (wr_idx == MY_IDX);
        always @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
                sync_r <= 3'b000;
                filt_r <= 1'b0;
                ctl_r <= `SFRM_RST_CMP;
                flag_r <= 1'b0;
            end else begin
                sync_r <= {sync_r[1:0], cmp_out_pin[gi]};
                if (stable) begin
                    filt_r <= sync_r[2];
                end
                if (wr_ctl) begin
                    ctl_r <= wr_dat[`SFRM_CMP_EN:2];
                end
                if (change) begin
                    flag_r <= 1'b1;
                end else if (wr_ctl && !wr_dat[`SFRM_CMP_FLAG]) begin
                    flag_r <= 1'b0;
                end
            end
        end
        assign comparator_cfg[gi*4 +: 4] = ctl_r;
        assign cmp_rd[gi*8 +: 8] = {2'b00, ctl_r, filt_r, flag_r};
        assign cmp_event[gi] = change;
    end
endgenerate

// interrupt status: write one to clear, a new event wins over the clear
assign irq_event = {twi_flag_set, flash_done, cmp_event};
assign irq_stat_nxt = (wr_byte && (wr_idx == `SFRM_IDX_IRQ_STAT)) ?
    ((irq_stat_r & ~hwdata[3:0]) | irq_event) : (irq_stat_r | irq_event);

always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        irq_stat_r <= `SFRM_RST_IRQ;
        irq_mask_r <= `SFRM_RST_IRQ;
        irq_r <= 1'b0;
    end else begin
        irq_stat_r <= irq_stat_nxt;
        if (wr_byte && (wr_idx == `SFRM_IDX_IRQ_MASK)) begin
            irq_mask_r <= hwdata[3:0];
        end
        // registered so the pin cannot glitch; it lags status by one cycle
        irq_r <= |(irq_stat_r & irq_mask_r);
    end
end

// read view; reserved bits read zero except the flash ones, which read one
always @* begin
    case (pend_idx_r)
        `SFRM_IDX_ACC: rd_nxt = {24'h000000, accumulator_r};
        `SFRM_IDX_BREG: rd_nxt = {24'h000000, multiply_divide_operand_r};
        `SFRM_IDX_PTR_LO: rd_nxt = {24'h000000, data_pointer_low_r};
        `SFRM_IDX_PTR_HI: rd_nxt = {24'h000000, data_pointer_high_r};
        `SFRM_IDX_CLKDIV: rd_nxt = {24'h000000, cpu_clock_divider_r};
        // the reset trigger is a pulse, so its bit always reads back zero
        `SFRM_IDX_AUX: rd_nxt = {24'h000000, clock_low_power_r, break_reset_enable_r,
            timer_one_toggle_enable_r, timer_zero_toggle_enable_r,
            1'b0, 1'b0, 1'b0, pointer_select_r};
        `SFRM_IDX_BAUD_CTL: rd_nxt = {30'h00000000, baud_source_select_r,
            baud_generator_enable_r};
        `SFRM_IDX_BAUD_LO: rd_nxt = {24'h000000, baud_divisor_low_r};
        `SFRM_IDX_BAUD_HI: rd_nxt = {24'h000000, baud_divisor_high_r};
        `SFRM_IDX_CMP_ONE: rd_nxt = {24'h000000, cmp_rd[7:0]};
        `SFRM_IDX_CMP_TWO: rd_nxt = {24'h000000, cmp_rd[15:8]};
        `SFRM_IDX_FLASH_ADR_LO: rd_nxt = {24'h000000, flash_address_low_r};
        `SFRM_IDX_FLASH_ADR_HI: rd_nxt = {24'h000000, flash_address_high_r};
        `SFRM_IDX_FLASH_DATA: rd_nxt = {24'h000000, flash_data_r};
        `SFRM_IDX_FLASH_CTL: rd_nxt = {24'h000000, flash_busy,
            `SFRM_FLASH_RSVD, flash_status};
        `SFRM_IDX_TWI_ADDR: rd_nxt = {24'h000000, twowire_own_address_r};
        `SFRM_IDX_TWI_CTL: rd_nxt = {24'h000000, 1'b0, twowire_control_r[6:2],
            1'b0, twowire_control_r[0]};
        `SFRM_IDX_TWI_DATA: rd_nxt = {24'h000000, twowire_data_r};
        `SFRM_IDX_BITOP: rd_nxt = {23'h000000, bit_val, bitop_addr_r};
        `SFRM_IDX_IRQ_STAT: rd_nxt = {28'h0000000, irq_stat_r};
        `SFRM_IDX_IRQ_MASK: rd_nxt = {28'h0000000, irq_mask_r};
        default: rd_nxt = 32'h00000000;
    endcase
end

endmodule // sfrm_regs

// ### sfrm_regs_checker.sv
// assertion checker for the special function register bank
module sfrm_regs_checker (
    input wire ref_clk,
    input wire rst_b,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hready,
    input wire [31:0] hrdata_r,
    input wire hreadyout_r,
    input wire hresp_r,
    input wire twi_flag_set,
    input wire software_reset_trigger_r,
    input wire [7:0] flash_command_code_r,
    input wire flash_command_strobe_r,
    input wire [7:0] accumulator_r,
    input wire [7:0] twowire_control_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    chk_okay_only: assert property (hresp_r == 1'b0)
        else $error("slave answered with an error response");
    chk_one_wait: assert property (hsel && hready && htrans == 2'b10 && hreadyout_r
        |=> !hreadyout_r ##1 hreadyout_r) else $error("transfer did not take one wait state");
    chk_rdata_hold: assert property (hreadyout_r |=> $stable(hrdata_r))
        else $error("read data moved while the slave was idle");
    chk_reset_values: assert property ($rose(rst_b) |-> accumulator_r == 8'h00
        && twowire_control_r == 8'h00 && flash_command_code_r == 8'h00)
        else $error("register not at its reset value");
    chk_twi_flag: assert property (twi_flag_set |=> twowire_control_r[3])
        else $error("two-wire flag not set by its event");
    // reserved control bits are driven low so downstream logic never sees junk
    chk_twi_reserved: assert property (!twowire_control_r[7] && !twowire_control_r[1])
        else $error("reserved two-wire control bit set");
    chk_cmd_on_write: assert property (!$stable(flash_command_code_r)
        |-> flash_command_strobe_r) else $error("command code changed without a write");
    chk_cmd_pulse: assert property (flash_command_strobe_r |=> !flash_command_strobe_r)
        else $error("command strobe longer than one cycle");
    chk_swrst_pulse: assert property (software_reset_trigger_r
        |=> !software_reset_trigger_r) else $error("software reset pulse too long");
endmodule // sfrm_regs_checker

bind sfrm_regs sfrm_regs_checker sfrm_regs_checker_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .hsel(hsel), .htrans(htrans), .hready(hready), .hrdata_r(hrdata_r),
    .hreadyout_r(hreadyout_r), .hresp_r(hresp_r), .twi_flag_set(twi_flag_set),
    .software_reset_trigger_r(software_reset_trigger_r),
    .flash_command_code_r(flash_command_code_r), .flash_command_strobe_r(flash_command_strobe_r),
    .accumulator_r(accumulator_r), .twowire_control_r(twowire_control_r));

// ### sfrm_regs_test.sv
// self-checking bench for the special function register bank
`include "sfrm_consts.vh"
module sfrm_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0;
    logic rst_b = 0;
    logic [31:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic hwrite = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 0;
    logic [1:0] cmp_out_pin = 0;
    logic flash_busy = 0;
    logic [3:0] flash_status = 0;
    logic twi_flag_set = 0;
    wire hready;
    wire [31:0] hrdata_r;
    wire [7:0] acc, breg, twi_ctl, cmd, cmp_cfg;
    wire [7:0] data_pointer_low, data_pointer_high, cdiv, bdl, bdh, fal, fah, fdat, twa;
    wire [4:0] aux;
    wire [1:0] bctl;
    wire irq;
    logic [31:0] rd;
    int err_count = 0;
    int compares = 0;
    logic [8:0] idx_tab [17] = '{9'h082, 9'h083, 9'h095, 9'h0a2, 9'h0ac, 9'h0ad, 9'h0bd,
        9'h0be, 9'h0bf, 9'h0d8, 9'h0db, 9'h0e0, 9'h0e4, 9'h0e5, 9'h0e6, 9'h0e7, 9'h0f0};
    logic [7:0] rst_tab [17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00, 8'h00, 8'h00};
    // reserved and fixed-zero bits are written low; read-only bits drop out on read-back
    logic [7:0] wr_tab [17] = '{8'hff, 8'hff, 8'hff, 8'hf9, 8'h3f, 8'h3f, 8'h03, 8'hff,
        8'hff, 8'h7d, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0] ff_tab [17] = '{8'hff, 8'hff, 8'hff, 8'hf1, 8'h3c, 8'h3c, 8'h03, 8'hff,
        8'hff, 8'h75, 8'hff, 8'hff, 8'h70, 8'hff, 8'hff, 8'hff, 8'hff};

    sfrm_regs sfrm_regs_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata_r(hrdata_r), .hreadyout_r(hready), .hresp_r(), .cmp_out_pin(cmp_out_pin),
        .flash_busy(flash_busy), .flash_status(flash_status), .twi_flag_set(twi_flag_set),
        .accumulator_r(acc), .multiply_divide_operand_r(breg), .data_pointer_low_r(data_pointer_low),
        .data_pointer_high_r(data_pointer_high), .cpu_clock_divider_r(cdiv), .clock_low_power_r(aux[4]),
        .break_reset_enable_r(aux[3]), .timer_one_toggle_enable_r(aux[2]),
        .timer_zero_toggle_enable_r(aux[1]), .software_reset_trigger_r(),
        .pointer_select_r(aux[0]), .baud_source_select_r(bctl[1]),
        .baud_generator_enable_r(bctl[0]), .baud_divisor_low_r(bdl), .baud_divisor_high_r(bdh),
        .comparator_cfg(cmp_cfg), .flash_address_low_r(fal), .flash_address_high_r(fah),
        .flash_data_r(fdat), .flash_command_code_r(cmd), .flash_command_strobe_r(),
        .twowire_own_address_r(twa), .twowire_control_r(twi_ctl), .irq_r(irq)
    );

    initial forever #20 ref_clk = ~ref_clk;

    // one single transfer; no cycle count is assumed, only hready decides
    task automatic xfer(input logic [8:0] idx, input logic wr, input logic [31:0] wd);
        haddr <= {21'h0, idx, 2'b00};
        htrans <= `SFRM_HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd = hrdata_r;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rchk(input logic [8:0] idx, input logic [31:0] exp);
        xfer(idx, 1'b0, 32'h0);
        check($sformatf("reg %h", idx), rd, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 17; i++) begin
                if (p > 0) xfer(idx_tab[i], 1'b1,
                    (p == 1) ? {24'h0, wr_tab[i]} : 32'h0);
                rchk(idx_tab[i], (p == 1) ? ff_tab[i] : rst_tab[i]);
            end
            if (p == 1) begin
                check("acc port", acc, 8'hff);
                check("cmp cfg", cmp_cfg, 8'hff);
                check("cmd code", cmd, 8'hff);
                check("twi ctl port", twi_ctl, 8'h75);
                check("pointer ports", {data_pointer_low, data_pointer_high, cdiv, bdl}, 32'hffffffff);
                check("flash ports", {bdh, fal, fah, fdat}, 32'hffffffff);
                check("ctl ports", {twa, aux, bctl}, 32'h7fff);
            end
        end
        $display("test register map done");
        xfer(9'h0a0, 1'b1, 32'h55);
        rchk(9'h0a0, 32'h0);
        xfer(`SFRM_IDX_TWI_DATA, 1'b1, 32'h5a);
        rchk(`SFRM_IDX_TWI_DATA, 32'h5a);
        $display("test unmapped done");
        xfer(`SFRM_IDX_BITOP, 1'b1, 32'h1e3);
        xfer(`SFRM_IDX_BITOP, 1'b1, 32'h1f7);
        xfer(`SFRM_IDX_BITOP, 1'b1, 32'h1de);
        rchk(`SFRM_IDX_BITOP, 32'h1de);
        rchk(`SFRM_IDX_ACC, 32'h08);
        check("b port", breg, 8'h80);
        check("twi ctl bit", twi_ctl, 8'h40);
        xfer(`SFRM_IDX_BITOP, 1'b1, 32'h0e3);
        rchk(`SFRM_IDX_ACC, 32'h00);
        $display("test bit access done");
        xfer(`SFRM_IDX_IRQ_MASK, 1'b1, 32'h8);
        twi_flag_set <= 1'b1;
        @(posedge ref_clk);
        twi_flag_set <= 1'b0;
        tick(3);
        check("irq on", irq, 1'b1);
        rchk(`SFRM_IDX_TWI_CTL, 32'h48);
        xfer(`SFRM_IDX_IRQ_STAT, 1'b1, 32'h8);
        tick(2);
        check("irq off", irq, 1'b0);
        xfer(`SFRM_IDX_IRQ_MASK, 1'b1, 32'h0);
        flash_busy <= 1'b1;
        flash_status <= 4'ha;
        tick(2);
        rchk(`SFRM_IDX_FLASH_CTL, 32'hfa);
        flash_busy <= 1'b0;
        tick(3);
        check("irq masked", irq, 1'b0);
        rchk(`SFRM_IDX_IRQ_STAT, 32'h4);
        xfer(`SFRM_IDX_IRQ_MASK, 1'b1, 32'hf);
        tick(2);
        check("irq unmasked", irq, 1'b1);
        // the pin passes a synchroniser, so allow it settling time
        xfer(`SFRM_IDX_CMP_ONE, 1'b1, 32'h20);
        cmp_out_pin <= 2'b01;
        tick(10);
        rchk(`SFRM_IDX_CMP_ONE, 32'h23);
        xfer(`SFRM_IDX_CMP_ONE, 1'b1, 32'h20);
        rchk(`SFRM_IDX_CMP_ONE, 32'h22);
        rchk(`SFRM_IDX_IRQ_STAT, 32'h5);
        xfer(`SFRM_IDX_IRQ_STAT, 1'b1, 32'hf);
        tick(2);
        check("irq cleared", irq, 1'b0);
        $display("test events done");
        report_and_stop();
    end
endmodule // sfrm_regs_test
